// File: artimer_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the reload timer
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes:   Printed offsets are register indices; byte address is four times the index
`ifndef ARTIMER_DEFS_SVH
`define ARTIMER_DEFS_SVH

`define IDX_RELOAD_LOW    8'h92
`define IDX_RELOAD_HIGH   8'h93
`define IDX_COUNT_LOW     8'h94
`define IDX_COUNT_HIGH    8'h95
`define IDX_CONTROL       8'h96
`define IDX_INT_STATUS    8'h97
`define IDX_INT_MASK      8'h98

`define CTL_OVF_BIT       7
`define CTL_RUN_BIT       2
`define CTL_DIV_BIT       1
`define CTL_XCLK_BIT      0
`define CTL_WR_MASK       8'h87
`define CTL_RESET         8'h00
`define BYTE_RESET        8'h00

`define SYSTEM_CLOCK_DIV        12
`define EXTOSC_DIV        8
`define AXI_RESP_OKAY     2'b00
`define AXI_RESP_SLVERR   2'b10

`endif

// File: artimer_pkg.sv
// Purpose: Types shared by the reload timer
// Assumes: Nothing beyond the defs header
// Notes:   Struct groups the software-visible control bits
package artimer_pkg;

  typedef struct packed {
    logic overflow_flag;
    logic run_control;
    logic system_clock_divide_select;
    logic ext_osc_clock_select;
  } timer_ctl_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_e;

endpackage

// File: autoreload_timer_rtc.sv
// Purpose: 16-bit auto-reload timer with system or external-oscillator timebase
// Assumes: aclk 10 MHz, synchronous active-low reset, AXI4-Lite slave, ext_osc sync to aclk
// Notes:   ext_osc is a level sampled on aclk; its rising edges are counted
// Functional notes
// - 16-bit up-counter readable and writable as low and high byte registers.
// - External select set: count external oscillator divided by 8, ignore divide select.
// - External select clear: count system clock divided by 12, or undivided if select set.
// - Always auto-reload; reload word is reload high and low bytes.
// - Set overflow flag when counter rolls over from 0xFFFF to the reload word.
// - With interrupt enabled, request interrupt whenever an overflow sets the interrupt status.
// - Overflow flag never cleared by hardware; only software write of zero.
// - Control bits 6 to 3 read zero; writes to them ignored.
// - Count only while run control is one; clearing it stops the timer.
// - No counter mode; never counts external pin transitions.
// - Overflow pulse offered as ADC start trigger and SMBus timing source.
// - Counter may run from oscillator timebase while logic uses system clock.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "artimer_defs.svh"

module autoreload_timer_rtc #(
  parameter int SYS_DIV = `SYSTEM_CLOCK_DIV,
  parameter int OSC_DIV = `EXTOSC_DIV
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator input
  input  wire logic        ext_osc,
  // Events
  output logic             overflow_trigger,
  output logic             irq
);
  import artimer_pkg::*;

  // Prescalers are 8 bits wide; refuse dividers they cannot hold
  if (SYS_DIV < 2 || SYS_DIV > 255 || OSC_DIV < 1 || OSC_DIV > 255) begin : g_div_range
    $error("autoreload_timer_rtc: divider out of range");
  end

  timer_ctl_s ctl_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic        int_status_q;
  logic        int_mask_q;
  logic [7:0]  sys_div_q;
  logic [7:0]  osc_div_q;
  logic        osc_s1_q;
  logic        osc_s2_q;
  logic        osc_s3_q;
  logic        tick;
  logic        sys_tick;
  logic        osc_tick;
  logic        overflow;

  // Write channel state
  wr_state_e   wr_state_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic [31:0] wr_data;
  logic        wr_lane0;
  logic        wr_hit;

  // Read channel state
  rd_state_e   rd_state_q;

  // Oscillator synchroniser, then edge detect on stage two and three
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= ext_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Oscillator prescaler: each rising edge counted once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_div_q <= 8'h00;
    end else if (osc_s2_q && !osc_s3_q) begin
      osc_div_q <= (osc_div_q == 8'(OSC_DIV - 1)) ? 8'h00 : osc_div_q + 8'h01;
    end
  end

  // System clock prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div_q <= 8'h00;
    end else begin
      sys_div_q <= (sys_div_q == 8'(SYS_DIV - 1)) ? 8'h00 : sys_div_q + 8'h01;
    end
  end

  assign osc_tick = osc_s2_q && !osc_s3_q && (osc_div_q == 8'(OSC_DIV - 1));
  assign sys_tick = ctl_q.system_clock_divide_select || (sys_div_q == 8'(SYS_DIV - 1));
  // Timebase select; no pin-driven count source exists
  assign tick = ctl_q.run_control && (ctl_q.ext_osc_clock_select ? osc_tick : sys_tick);
  assign overflow = tick && (count_q == 16'hFFFF);

  // Bus write decode
  assign wr_fire  = (wr_state_q == WR_IDLE) && aw_held_q && w_held_q;
  assign wr_idx   = aw_idx_q;
  assign wr_data  = w_data_q;
  assign wr_lane0 = w_strb_q[0];
  assign wr_hit   = (wr_idx >= `IDX_RELOAD_LOW) && (wr_idx <= `IDX_INT_MASK);

  // Counter: software byte writes win over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= {`BYTE_RESET, `BYTE_RESET};
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_COUNT_LOW) begin
      count_q[7:0] <= wr_data[7:0];
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_COUNT_HIGH) begin
      count_q[15:8] <= wr_data[7:0];
    end else if (overflow) begin
      count_q <= reload_q;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Reload bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= {`BYTE_RESET, `BYTE_RESET};
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_RELOAD_LOW) begin
      reload_q[7:0] <= wr_data[7:0];
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_RELOAD_HIGH) begin
      reload_q[15:8] <= wr_data[7:0];
    end
  end

  // Control register; overflow set beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= timer_ctl_s'(4'h0);
    end else begin
      if (wr_fire && wr_lane0 && wr_idx == `IDX_CONTROL) begin
        ctl_q.run_control          <= wr_data[`CTL_RUN_BIT];
        ctl_q.system_clock_divide_select <= wr_data[`CTL_DIV_BIT];
        ctl_q.ext_osc_clock_select <= wr_data[`CTL_XCLK_BIT];
        ctl_q.overflow_flag        <= wr_data[`CTL_OVF_BIT] | overflow;
      end else if (overflow) begin
        ctl_q.overflow_flag <= 1'b1;
      end
    end
  end

  // Sticky status, write one to clear; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_q <= 1'b0;
    end else if (overflow) begin
      int_status_q <= 1'b1;
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_INT_STATUS && wr_data[0]) begin
      int_status_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask_q <= 1'b0;
    end else if (wr_fire && wr_lane0 && wr_idx == `IDX_INT_MASK) begin
      int_mask_q <= wr_data[0];
    end
  end

  // Interrupt follows sticky status while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= int_mask_q && (int_status_q || overflow);
    end
  end

  // One-cycle trigger for converter start and bus timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_trigger <= 1'b0;
    end else begin
      overflow_trigger <= overflow;
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= (s_axi_awaddr[1:0] == 2'b00 && s_axi_awaddr[31:10] == 22'h00_0000)
                     ? s_axi_awaddr[9:2] : 8'h00;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Ready outputs registered: high while slot empty and no write response pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !(aw_held_q || (s_axi_awvalid && s_axi_awready)) && (wr_state_q == WR_IDLE);
      s_axi_wready  <= !(w_held_q || (s_axi_wvalid && s_axi_wready)) && (wr_state_q == WR_IDLE);
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q   <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q   <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q   <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // Read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q    <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rd_state_q    <= RD_RESP;
            s_axi_rresp   <= `AXI_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr[31:10] != 22'h00_0000) begin
              s_axi_rresp <= `AXI_RESP_SLVERR;
            end else begin
              case (s_axi_araddr[9:2])
                `IDX_RELOAD_LOW:  s_axi_rdata[7:0] <= reload_q[7:0];
                `IDX_RELOAD_HIGH: s_axi_rdata[7:0] <= reload_q[15:8];
                `IDX_COUNT_LOW:   s_axi_rdata[7:0] <= count_q[7:0];
                `IDX_COUNT_HIGH:  s_axi_rdata[7:0] <= count_q[15:8];
                `IDX_CONTROL: begin
                  s_axi_rdata[`CTL_OVF_BIT]  <= ctl_q.overflow_flag;
                  s_axi_rdata[`CTL_RUN_BIT]  <= ctl_q.run_control;
                  s_axi_rdata[`CTL_DIV_BIT]  <= ctl_q.system_clock_divide_select;
                  s_axi_rdata[`CTL_XCLK_BIT] <= ctl_q.ext_osc_clock_select;
                end
                `IDX_INT_STATUS:  s_axi_rdata[0] <= int_status_q;
                `IDX_INT_MASK:    s_axi_rdata[0] <= int_mask_q;
                default:          s_axi_rresp <= `AXI_RESP_SLVERR;
              endcase
            end
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_q   <= RD_IDLE;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  // Checks
  ovf_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && !(wr_fire && wr_idx inside {`IDX_COUNT_LOW, `IDX_COUNT_HIGH}) |=> count_q == $past(reload_q))
    else $error("counter did not take reload value on overflow");
  ovf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> ctl_q.overflow_flag && overflow_trigger)
    else $error("overflow flag or trigger missing");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_q.overflow_flag && !(wr_fire && wr_idx == `IDX_CONTROL) |=> ctl_q.overflow_flag)
    else $error("overflow flag cleared by hardware");
  stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_q.run_control && !wr_fire |=> count_q == $past(count_q))
    else $error("counter moved while stopped");
  fast_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_q.run_control && ctl_q.system_clock_divide_select && !ctl_q.ext_osc_clock_select
    && count_q != 16'hFFFF && !wr_fire |=> count_q == $past(count_q) + 16'h0001)
    else $error("undivided count step wrong");
  osc_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_q.ext_osc_clock_select && !(osc_s2_q && !osc_s3_q) && !wr_fire |=> count_q == $past(count_q))
    else $error("counted without oscillator edge");
  irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    int_mask_q && overflow |=> irq)
    else $error("interrupt not raised on overflow");
  slow_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !ctl_q.system_clock_divide_select && !ctl_q.ext_osc_clock_select && !wr_fire |=> !tick)
    else $error("divided timebase ticked twice in a row");
  trig_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow_trigger |-> $past(overflow))
    else $error("trigger without overflow");
  osc_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_tick |=> !osc_tick)
    else $error("oscillator event duplicated");

endmodule

// File: tb_artimer.sv
// Purpose: Self-checking bench for the auto-reload timer through its AXI4-Lite registers
// Assumes: Byte address is four times the register index; ext_osc driven in step with aclk
// Notes:   Rate checks accept count windows of 2 to 8 values for prescaler phase and bus delay
`timescale 1ns/1ps
`include "artimer_defs.svh"

module testbench;
  logic        aclk;
  logic        aresetn;
  logic [31:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        ext_osc;
  logic        overflow_trigger;
  logic        irq;
  int          fails;
  int          check_count;
  int          trig_n;
  int          n;
  logic [31:0] d;

  autoreload_timer_rtc #(.SYS_DIV(`SYSTEM_CLOCK_DIV), .OSC_DIV(`EXTOSC_DIV)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_osc(ext_osc),
    .overflow_trigger(overflow_trigger), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Counts one-cycle trigger pulses
  always @(posedge aclk) begin
    if (overflow_trigger === 1'b1)
      trig_n <= trig_n + 1;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    fails++;
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb, input logic [1:0] er);
    int k;
    s_axi_awaddr  <= {22'h0, idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h00_0000, val};
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
    end
    if (k == 64)
      timeout();
  endtask

  task automatic rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] val);
    int k;
    s_axi_araddr  <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        val = s_axi_rdata;
        break;
      end
    end
    if (k == 64)
      timeout();
  endtask

  task automatic w1(input logic [7:0] idx, input logic [7:0] val);
    wr(idx, val, 4'h1, `AXI_RESP_OKAY);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx, `AXI_RESP_OKAY, d);
    chk(d, {24'h00_0000, exp});
  endtask

  task automatic range_chk(input logic [7:0] idx, input int lo, input int hi);
    rd(idx, `AXI_RESP_OKAY, d);
    chk({31'h0, (d >= lo && d <= hi)}, 32'h0000_0001);
  endtask

  task automatic clear_count();
    w1(`IDX_COUNT_LOW, 8'h00);
    w1(`IDX_COUNT_HIGH, 8'h00);
  endtask

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0000_0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ext_osc = 1'b0;
    fails = 0;
    check_count = 0;
    trig_n = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (n = 0; n < 7; n++)
      rchk(`IDX_RELOAD_LOW + n[7:0], 8'h00);
    rd(8'h99, `AXI_RESP_SLVERR, d);
    chk(d, 32'h0000_0000);
    wr(8'h99, 8'h55, 4'h1, `AXI_RESP_SLVERR);
    // Unused control bits
    w1(`IDX_CONTROL, 8'h7A);
    rchk(`IDX_CONTROL, 8'h02);
    w1(`IDX_CONTROL, 8'h00);
    w1(`IDX_RELOAD_LOW, 8'hA5);
    w1(`IDX_RELOAD_HIGH, 8'h5A);
    rchk(`IDX_RELOAD_LOW, 8'hA5);
    rchk(`IDX_RELOAD_HIGH, 8'h5A);
    w1(`IDX_COUNT_LOW, 8'h34);
    w1(`IDX_COUNT_HIGH, 8'h12);
    wr(`IDX_COUNT_LOW, 8'hFF, 4'h0, `AXI_RESP_OKAY);
    repeat (50) @(posedge aclk);
    rchk(`IDX_COUNT_LOW, 8'h34);
    rchk(`IDX_COUNT_HIGH, 8'h12);
    // Overflow from 0xFFFC on the undivided clock
    w1(`IDX_INT_MASK, 8'h01);
    w1(`IDX_COUNT_LOW, 8'hFC);
    w1(`IDX_COUNT_HIGH, 8'hFF);
    w1(`IDX_CONTROL, 8'h06);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (overflow_trigger === 1'b1)
        break;
    end
    if (n == 40)
      timeout();
    chk({31'h0, irq}, 32'h0000_0001);
    w1(`IDX_CONTROL, 8'h80);
    chk(trig_n, 1);
    rchk(`IDX_CONTROL, 8'h80);
    rchk(`IDX_COUNT_HIGH, 8'h5A);
    range_chk(`IDX_COUNT_LOW, 8'hA5, 8'hB5);
    repeat (40) @(posedge aclk);
    rchk(`IDX_CONTROL, 8'h80);
    rchk(`IDX_INT_STATUS, 8'h01);
    w1(`IDX_INT_MASK, 8'h00);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    w1(`IDX_INT_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    w1(`IDX_INT_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    w1(`IDX_CONTROL, 8'h00);
    rchk(`IDX_CONTROL, 8'h00);
    // Divide by twelve, then undivided
    clear_count();
    w1(`IDX_CONTROL, 8'h04);
    repeat (240) @(posedge aclk);
    w1(`IDX_CONTROL, 8'h00);
    range_chk(`IDX_COUNT_LOW, 19, 22);
    clear_count();
    w1(`IDX_CONTROL, 8'h06);
    repeat (40) @(posedge aclk);
    w1(`IDX_CONTROL, 8'h00);
    range_chk(`IDX_COUNT_LOW, 40, 47);
    // Oscillator timebase: idle pin must not count
    clear_count();
    w1(`IDX_CONTROL, 8'h07);
    repeat (100) @(posedge aclk);
    rchk(`IDX_COUNT_LOW, 8'h00);
    repeat (64) begin
      ext_osc <= 1'b1;
      repeat (2) @(posedge aclk);
      ext_osc <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    w1(`IDX_CONTROL, 8'h00);
    range_chk(`IDX_COUNT_LOW, 7, 8);
    rchk(`IDX_COUNT_HIGH, 8'h00);
    print_verdict();
  end
endmodule
